/* include/sweep_capture_pkg.sv */
/*
 * Shared constants and carrier types for the sweep X/Y capture block.
 * Assumes a single 200 MHz clock domain and an external DMA bus partner.
 */
package sweep_capture_pkg;

    localparam int X_WIDTH       = 10;
    localparam int Y_WIDTH       = 8;
    localparam int CLK_PERIOD_PS = 5000;

    // comparator and D/A settle time before the X comparator is trusted
    localparam int SETTLE_NS     = 50;
    localparam int SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // per-bit settle time of the Y successive-approximation search
    localparam int SAR_BIT_NS    = 100;
    localparam int SAR_BIT_CYC   = (SAR_BIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // memory select strobe length during the DMA write
    localparam int WRITE_NS      = 20;
    localparam int WRITE_CYC     = (WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int CNT_W         = 8;

    localparam logic [X_WIDTH-1:0] X_RESET = 10'h000;
    localparam logic [Y_WIDTH-1:0] Y_RESET = 8'h00;

    // one captured display point
    typedef struct packed {
        logic [X_WIDTH-1:0] x;
        logic [Y_WIDTH-1:0] y;
    } sample_pair_t;

    localparam int PAIR_W = X_WIDTH + Y_WIDTH;

endpackage : sweep_capture_pkg

/* design/pair_buffer.sv */
/*
 * Two-entry valid/ready buffer for captured sample pairs.
 * Assumes both sides on the same clock; no word is lost on a drain stall.
 */
`timescale 1ns/1ps
`default_nettype none

module pair_buffer #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // pointer and occupancy update; full blocks the source, empty blocks the sink
    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        in_ready = cnt_q != (PW+1)'(DEPTH);
        out_valid = cnt_q != '0;
        out_data = mem_q[rd_q];
        mem_d    = mem_q;
        wr_d     = wr_q;
        rd_d     = rd_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d        = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule : pair_buffer

`default_nettype wire

/* design/sweep_xy_adc_dma_capture.sv */
/*
 * Display digitiser control: X counter/D-A tracking of the sweep ramp,
 * Y successive-approximation search of the peak-detected video, and a
 * DMA write of each X/Y pair into host display memory.
 * Assumes analog comparators and the bus grant arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: X counter drives D/A, watch ramp comparator
// RULE2: comparator trip latches X, pulses Y start
// RULE3: Y uses successive-approximation search of peak
// RULE4: peak detector positive or negative mode selectable
// RULE5: Y conversion starts only on X start
// RULE6: final SAR result held in Y latch
// RULE7: request bus, wait grant, then select memory
// RULE8: write latched X and Y while granted
// RULE9: latches drive bus only during select
// RULE10: Z-axis signal resets X counter each sweep
// RULE11: after write release request, select, rearm
// RULE12: X counter advances monotonically during sweep
module sweep_xy_adc_dma_capture #(
    parameter int X_WIDTH = sweep_capture_pkg::X_WIDTH,
    parameter int Y_WIDTH = sweep_capture_pkg::Y_WIDTH
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // sweep side
    input  wire logic                x_comparator,
    input  wire logic                z_axis_reset,
    output logic [X_WIDTH-1:0]       x_dac_code,
    // peak detector and Y converter
    input  wire logic                positive_peak_mode,
    output logic                     negative_peak_mode,
    output logic [Y_WIDTH-1:0]       sar_result_bits,
    input  wire logic                y_comparator,
    output logic                     y_conv_start_n,
    output logic                     y_busy,
    // host bus
    output logic                     bus_request_n,
    input  wire logic                bus_grant_n,
    output logic                     display_mem_select_n,
    output logic [X_WIDTH+Y_WIDTH-1:0] bus_data_out,
    output logic                     bus_data_oe
);
    localparam int PW = X_WIDTH + Y_WIDTH;

    // two-flop synchronisers for pins
    logic [1:0] xcmp_s, zax_s, ycmp_s, gnt_s;
    logic       xcmp_prev_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            xcmp_s      <= 2'h0;
            zax_s       <= 2'h0;
            ycmp_s      <= 2'h0;
            gnt_s       <= 2'h3;
            xcmp_prev_q <= 1'b0;
        end else begin
            xcmp_s      <= {xcmp_s[0], x_comparator};
            zax_s       <= {zax_s[0], z_axis_reset};
            ycmp_s      <= {ycmp_s[0], y_comparator};
            gnt_s       <= {gnt_s[0], bus_grant_n};
            xcmp_prev_q <= xcmp_s[1];
        end
    end

    // X converter: counter feeds D/A; a comparator change captures it
    typedef enum logic [1:0] {X_SETTLE, X_WATCH, X_HOLD} x_state_t;
    x_state_t                           x_st_q, x_st_d;
    logic [X_WIDTH-1:0]                 x_cnt_q, x_cnt_d, x_lat_q, x_lat_d;
    logic [sweep_capture_pkg::CNT_W-1:0] x_tmr_q, x_tmr_d;
    logic                               ystart_q, ystart_d;
    logic                               y_idle;
    logic                               x_trip;

    always_comb begin
        x_st_d   = x_st_q;
        x_cnt_d  = x_cnt_q;
        x_lat_d  = x_lat_q;
        x_tmr_d  = x_tmr_q;
        ystart_d = 1'b0;
        x_trip   = xcmp_s[1] != xcmp_prev_q;
        if (zax_s[1]) begin
            x_cnt_d = sweep_capture_pkg::X_RESET; // RULE10
            x_tmr_d = '0;
            x_st_d  = X_SETTLE;
        end else begin
            unique case (x_st_q)
                X_SETTLE: begin
                    // ignore comparator until D/A output has settled
                    if (x_tmr_q == sweep_capture_pkg::CNT_W'(sweep_capture_pkg::SETTLE_CYC - 1)) begin
                        x_st_d = X_WATCH;
                    end else begin
                        x_tmr_d = x_tmr_q + 1'b1;
                    end
                end
                X_WATCH: begin
                    if (x_trip) begin // RULE1
                        x_lat_d = x_cnt_q;  // RULE2
                        x_st_d  = X_HOLD;
                    end
                end
                X_HOLD: begin
                    // start Y only when its sequencer is free, else wait
                    if (y_idle) begin
                        ystart_d = 1'b1; // RULE2
                        if (x_cnt_q != '1) begin
                            x_cnt_d = x_cnt_q + 1'b1; // RULE12
                        end
                        x_tmr_d = '0;
                        x_st_d  = X_SETTLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            x_st_q   <= X_SETTLE;
            x_cnt_q  <= sweep_capture_pkg::X_RESET;
            x_lat_q  <= sweep_capture_pkg::X_RESET;
            x_tmr_q  <= '0;
            ystart_q <= 1'b0;
        end else begin
            x_st_q   <= x_st_d;
            x_cnt_q  <= x_cnt_d;
            x_lat_q  <= x_lat_d;
            x_tmr_q  <= x_tmr_d;
            ystart_q <= ystart_d;
        end
    end

    assign x_dac_code         = x_cnt_q; // RULE1
    assign y_conv_start_n     = ~ystart_q;
    assign negative_peak_mode = ~positive_peak_mode; // RULE4

    // Y converter: SAR search, one bit per settle period
    typedef enum logic [1:0] {Y_IDLE, Y_TRIAL, Y_PUSH} y_state_t;
    y_state_t                           y_st_q, y_st_d;
    logic [Y_WIDTH-1:0]                 sar_q, sar_d, bit_q, bit_d, y_lat_q, y_lat_d;
    logic [sweep_capture_pkg::CNT_W-1:0] y_tmr_q, y_tmr_d;
    logic [X_WIDTH-1:0]                 xp_q, xp_d;
    logic                               buf_in_ready, buf_out_valid;
    logic [PW-1:0]                      buf_out;
    logic                               push;

    always_comb begin
        y_st_d  = y_st_q;
        sar_d   = sar_q;
        bit_d   = bit_q;
        y_lat_d = y_lat_q;
        y_tmr_d = y_tmr_q;
        xp_d    = xp_q;
        push    = 1'b0;
        y_idle  = y_st_q == Y_IDLE;
        unique case (y_st_q)
            Y_IDLE: begin
                if (ystart_q) begin // RULE5
                    xp_d    = x_lat_q;
                    bit_d   = {1'b1, {(Y_WIDTH-1){1'b0}}};
                    sar_d   = {1'b1, {(Y_WIDTH-1){1'b0}}};
                    y_tmr_d = '0;
                    y_st_d  = Y_TRIAL;
                end
            end
            Y_TRIAL: begin
                if (y_tmr_q == sweep_capture_pkg::CNT_W'(sweep_capture_pkg::SAR_BIT_CYC - 1)) begin
                    y_tmr_d = '0;
                    // comparator high: trial code above input, drop the bit
                    if (ycmp_s[1]) begin
                        sar_d = sar_q & ~bit_q; // RULE3
                    end
                    if (bit_q[0]) begin
                        y_lat_d = ycmp_s[1] ? (sar_q & ~bit_q) : sar_q; // RULE6
                        y_st_d  = Y_PUSH;
                    end else begin
                        bit_d = bit_q >> 1;
                        sar_d = (ycmp_s[1] ? (sar_q & ~bit_q) : sar_q) | (bit_q >> 1);
                    end
                end else begin
                    y_tmr_d = y_tmr_q + 1'b1;
                end
            end
            Y_PUSH: begin
                // stalls here when the buffer is full, holding off new starts
                push = 1'b1;
                if (buf_in_ready) begin
                    y_st_d = Y_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            y_st_q  <= Y_IDLE;
            sar_q   <= sweep_capture_pkg::Y_RESET;
            bit_q   <= sweep_capture_pkg::Y_RESET;
            y_lat_q <= sweep_capture_pkg::Y_RESET;
            y_tmr_q <= '0;
            xp_q    <= sweep_capture_pkg::X_RESET;
        end else begin
            y_st_q  <= y_st_d;
            sar_q   <= sar_d;
            bit_q   <= bit_d;
            y_lat_q <= y_lat_d;
            y_tmr_q <= y_tmr_d;
            xp_q    <= xp_d;
        end
    end

    assign sar_result_bits = sar_q; // RULE3
    assign y_busy          = y_st_q != Y_IDLE;

    sweep_capture_pkg::sample_pair_t pair_in;
    assign pair_in.x = xp_q;
    assign pair_in.y = y_lat_q;

    logic buf_pop;

    pair_buffer #(
        .WIDTH (PW),
        .DEPTH (2)
    ) u_buf (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   (pair_in),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_out)
    );

    // DMA: request, wait for grant, strobe select, release
    typedef enum logic [1:0] {D_IDLE, D_REQ, D_WRITE, D_DONE} d_state_t;
    d_state_t                           d_st_q, d_st_d;
    logic [sweep_capture_pkg::CNT_W-1:0] d_tmr_q, d_tmr_d;
    logic                               req_q, req_d, sel_q, sel_d;
    logic [PW-1:0]                      dout_q, dout_d;

    always_comb begin
        d_st_d  = d_st_q;
        d_tmr_d = d_tmr_q;
        req_d   = req_q;
        sel_d   = sel_q;
        dout_d  = dout_q;
        buf_pop = 1'b0;
        unique case (d_st_q)
            D_IDLE: begin
                if (buf_out_valid) begin
                    req_d  = 1'b1; // RULE7
                    d_st_d = D_REQ;
                end
            end
            D_REQ: begin
                if (!gnt_s[1]) begin
                    sel_d   = 1'b1; // RULE7
                    dout_d  = buf_out; // RULE8
                    buf_pop = 1'b1;
                    d_tmr_d = '0;
                    d_st_d  = D_WRITE;
                end
            end
            D_WRITE: begin
                if (d_tmr_q == sweep_capture_pkg::CNT_W'(sweep_capture_pkg::WRITE_CYC - 1)) begin
                    sel_d  = 1'b0; // RULE11
                    req_d  = 1'b0; // RULE11
                    d_st_d = D_DONE;
                end else begin
                    d_tmr_d = d_tmr_q + 1'b1;
                end
            end
            D_DONE: begin
                // wait for the host to drop its grant before re-requesting
                if (gnt_s[1]) begin
                    d_st_d = D_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            d_st_q  <= D_IDLE;
            d_tmr_q <= '0;
            req_q   <= 1'b0;
            sel_q   <= 1'b0;
            dout_q  <= '0;
        end else begin
            d_st_q  <= d_st_d;
            d_tmr_q <= d_tmr_d;
            req_q   <= req_d;
            sel_q   <= sel_d;
            dout_q  <= dout_d;
        end
    end

    assign bus_request_n        = ~req_q;
    assign display_mem_select_n = ~sel_q;
    assign bus_data_oe          = sel_q; // RULE9
    assign bus_data_out         = dout_q;

endmodule : sweep_xy_adc_dma_capture

`default_nettype wire

/* verification/sweep_capture_checker_assertions.sv */
/* Concurrent checks on the sweep capture block's ports.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none

module sweep_capture_checker #(
    parameter int X_WIDTH = 10,
    parameter int Y_WIDTH = 8
) (
    // clock and reset
    input wire logic                       ref_clk,
    input wire logic                       reset_n,
    // sweep and converters
    input wire logic                       x_comparator,
    input wire logic                       z_axis_reset,
    input wire logic [X_WIDTH-1:0]         x_dac_code,
    input wire logic                       positive_peak_mode,
    input wire logic                       negative_peak_mode,
    input wire logic [Y_WIDTH-1:0]         sar_result_bits,
    input wire logic                       y_comparator,
    input wire logic                       y_conv_start_n,
    input wire logic                       y_busy,
    // host bus
    input wire logic                       bus_request_n,
    input wire logic                       bus_grant_n,
    input wire logic                       display_mem_select_n,
    input wire logic [X_WIDTH+Y_WIDTH-1:0] bus_data_out,
    input wire logic                       bus_data_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // the write strobe is four cycles long, then select and request drop together
    sequence s_sel_held;
        !display_mem_select_n [*4];
    endsequence
    sequence s_release;
        display_mem_select_n && bus_request_n && !bus_data_oe;
    endsequence

    property p_oe_select;
        bus_data_oe == !display_mem_select_n;
    endproperty
    property p_sel_grant;
        $fell(display_mem_select_n) |-> !bus_request_n && !bus_grant_n && !$past(bus_grant_n, 2);
    endproperty
    property p_write_len;
        $fell(display_mem_select_n) |-> s_sel_held ##1 s_release;
    endproperty
    property p_data_stable;
        !display_mem_select_n && !$past(display_mem_select_n) |-> $stable(bus_data_out);
    endproperty
    property p_start_pulse;
        !y_conv_start_n |=> y_conv_start_n && y_busy;
    endproperty
    property p_start_idle;
        $fell(y_conv_start_n) |-> !y_busy;
    endproperty
    property p_x_step;
        $fell(y_conv_start_n) && !$past(z_axis_reset) && $past(x_dac_code) != '1
            |-> x_dac_code == $past(x_dac_code) + 1'b1;
    endproperty
    // a conversion may only begin one cycle after the start request
    property p_busy_cause;
        $rose(y_busy) |-> !$past(y_conv_start_n);
    endproperty
    property p_z_clear;
        z_axis_reset [*6] |-> x_dac_code == '0;
    endproperty
    property p_sar_msb;
        $fell(y_conv_start_n) |-> ##[1:2] sar_result_bits == {1'b1, {(Y_WIDTH-1){1'b0}}};
    endproperty
    property p_result_held;
        !y_busy && !$past(y_busy) |-> $stable(sar_result_bits);
    endproperty
    property p_peak_mode;
        negative_peak_mode == !positive_peak_mode;
    endproperty

    a_oe_select: assert property (p_oe_select) else $error("oe differs from select");
    a_sel_grant: assert property (p_sel_grant) else $error("select without grant");
    a_write_len: assert property (p_write_len) else $error("write strobe length");
    a_data_stable: assert property (p_data_stable) else $error("data moved in write");
    a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
    a_start_idle: assert property (p_start_idle) else $error("start while busy");
    a_busy_cause: assert property (p_busy_cause) else $error("y started without request");
    a_x_step: assert property (p_x_step) else $error("x count not stepped");
    a_z_clear: assert property (p_z_clear) else $error("z did not clear x");
    a_sar_msb: assert property (p_sar_msb) else $error("first trial not msb");
    a_result_held: assert property (p_result_held) else $error("y result moved");
    a_peak_mode: assert property (p_peak_mode) else $error("peak mode outputs");
endmodule : sweep_capture_checker

bind sweep_xy_adc_dma_capture sweep_capture_checker #(
    .X_WIDTH(X_WIDTH), .Y_WIDTH(Y_WIDTH)
) u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .x_comparator(x_comparator),
    .z_axis_reset(z_axis_reset), .x_dac_code(x_dac_code),
    .positive_peak_mode(positive_peak_mode), .negative_peak_mode(negative_peak_mode),
    .sar_result_bits(sar_result_bits), .y_comparator(y_comparator),
    .y_conv_start_n(y_conv_start_n), .y_busy(y_busy), .bus_request_n(bus_request_n),
    .bus_grant_n(bus_grant_n), .display_mem_select_n(display_mem_select_n),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe)
);

`default_nettype wire

/* verification/host_bus_model.sv */
/* Host board model: grants the bus after a set delay, logs display writes.
   Assumes request and select come registered from the capture block. */
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
    // clock and reset
    input wire logic                                 ref_clk,
    input wire logic                                 reset_n,
    // bus handshake, delay set by the bench
    input wire logic                                 bus_request_n,
    output logic                                     bus_grant_n,
    input wire logic [9:0]                           grant_delay,
    // display memory write
    input wire logic                                 display_mem_select_n,
    input wire logic [sweep_capture_pkg::PAIR_W-1:0] bus_data_out
);
    logic [sweep_capture_pkg::PAIR_W-1:0] words [$];
    logic [9:0]                           wait_q;
    logic                                 sel_prev_q;

    // grant held until request drops, so a slow host stalls the block
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_grant_n <= 1'b1;
            wait_q <= 10'h000;
            sel_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= display_mem_select_n;
            if (bus_request_n) begin
                bus_grant_n <= 1'b1;
                wait_q <= 10'h000;
            end else if (wait_q >= grant_delay) begin
                bus_grant_n <= 1'b0;
            end else begin
                wait_q <= wait_q + 10'h001;
            end
            // one word logged per select strobe
            if (!display_mem_select_n && sel_prev_q) begin
                words.push_back(bus_data_out);
            end
        end
    end
endmodule : host_bus_model

`default_nettype wire

/* verification/tb_sweep_xy_adc_dma_capture.sv */
/* Self-checking bench for the sweep capture block.
   Assumes the host bus model in its own file and the bound checker. */
`timescale 1ns/1ps
`default_nettype none

module tb_sweep_xy_adc_dma_capture;
    localparam int PW = sweep_capture_pkg::PAIR_W;
    localparam int XW = sweep_capture_pkg::X_WIDTH;
    localparam int YW = sweep_capture_pkg::Y_WIDTH;
    logic          ref_clk, reset_n, x_comparator, z_axis_reset, positive_peak_mode;
    logic          y_comparator, negative_peak_mode, y_conv_start_n, y_busy, bus_request_n;
    logic          bus_grant_n, display_mem_select_n, bus_data_oe;
    logic [XW-1:0] x_dac_code, x_exp;
    logic [YW-1:0] sar_result_bits, y_level;
    logic [PW-1:0] bus_data_out;
    logic [PW-1:0] q_exp [$];
    logic [9:0]    grant_delay;
    logic [31:0]   rnd;
    int            mismatches, checked, cycles;

    sweep_xy_adc_dma_capture u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .x_comparator(x_comparator),
        .z_axis_reset(z_axis_reset), .x_dac_code(x_dac_code),
        .positive_peak_mode(positive_peak_mode), .negative_peak_mode(negative_peak_mode),
        .sar_result_bits(sar_result_bits), .y_comparator(y_comparator),
        .y_conv_start_n(y_conv_start_n), .y_busy(y_busy), .bus_request_n(bus_request_n),
        .bus_grant_n(bus_grant_n), .display_mem_select_n(display_mem_select_n),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe)
    );
    host_bus_model u_host (
        .ref_clk(ref_clk), .reset_n(reset_n), .bus_request_n(bus_request_n),
        .bus_grant_n(bus_grant_n), .grant_delay(grant_delay),
        .display_mem_select_n(display_mem_select_n), .bus_data_out(bus_data_out)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // expected bus word: x above y
    function automatic logic [PW-1:0] pair_word(input logic [XW-1:0] x, input logic [YW-1:0] y);
        return {x, y};
    endfunction : pair_word

    task automatic compare(input logic [PW-1:0] got, input logic [PW-1:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic final_report();
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // toggle the comparator, wait for the start pulse, then out the settle window
    task automatic trip();
        int n;
        n = 0;
        @(posedge ref_clk);
        #1 x_comparator = ~x_comparator;
        while (y_conv_start_n !== 1'b0 && n < 3000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        compare(PW'(n < 3000), PW'(1));
        compare(PW'(x_dac_code), PW'(x_exp + 1'b1));
        q_exp.push_back(pair_word(x_exp, y_level));
        x_exp++;
        repeat (14) @(posedge ref_clk);
    endtask : trip

    // pull every expected word out of the host log, in order
    task automatic drain();
        int n;
        n = 0;
        while (q_exp.size() > 0 && n < 5000) begin
            @(posedge ref_clk);
            #1 n++;
            if (u_host.words.size() > 0) begin
                compare(u_host.words.pop_front(), q_exp.pop_front());
            end
        end
        compare(PW'(q_exp.size()), PW'(0));
        // strobe ends a few cycles after the word is logged
        repeat (8) @(posedge ref_clk);
        #1 compare(PW'({bus_request_n, display_mem_select_n, bus_data_oe}), PW'(3'h6));
    endtask : drain

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // analog input held at y_level: high means trial code is above it
    always @(posedge ref_clk) begin
        #1 y_comparator = (sar_result_bits > y_level);
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        reset_n = 1'b0;
        x_comparator = 1'b0;
        z_axis_reset = 1'b0;
        positive_peak_mode = 1'b1;
        y_comparator = 1'b0;
        y_level = 8'h00;
        grant_delay = 10'h000;
        rnd = 32'h8bd5b243;
        x_exp = '0;
        mismatches = 0;
        checked = 0;
        cycles = 0;
        repeat (4) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (14) @(posedge ref_clk);
        #1 compare(PW'(x_dac_code), PW'(0));
        // single points: extreme levels first, then random level, mode and grant delay
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr_next(rnd);
            y_level = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
            positive_peak_mode = rnd[8];
            grant_delay = {6'h00, rnd[12:9]};
            #1 compare(PW'(negative_peak_mode ^ positive_peak_mode), PW'(1));
            trip();
            drain();
        end
        // slow host: points pile up until the buffer refuses, then drain
        rnd = lfsr_next(rnd);
        y_level = rnd[7:0];
        grant_delay = 10'h2bc;
        repeat (5) trip();
        drain();
        // sweep restart clears the counter
        z_axis_reset = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 compare(PW'(x_dac_code), PW'(0));
        z_axis_reset = 1'b0;
        x_exp = '0;
        grant_delay = 10'h003;
        repeat (14) @(posedge ref_clk);
        trip();
        drain();
        final_report();
    end
endmodule : tb_sweep_xy_adc_dma_capture

`default_nettype wire
